// ---- agu_top.sv ----
// Address generation unit: table lanes, byte loads, direct reach, stack, modulo and bit-reversed EA
//
// Behaviour
// R1: Low-lane word table read returns program bits 15:0 unchanged.
// R2: Low-lane byte read gives bits 7:0 for select 0, bits 15:8 for select 1.
// R3: High-lane word read puts program bits 23:16 in low byte, high byte zero.
// R4: High-lane byte read gives bits 23:16 for select 0, zero for select 1.
// R5: Program counter advances by two per program word.
// R6: Byte loads write only the low byte of a working register.
// R7: Memory-direct instructions reach 0x0000 to 0x1FFF via 13-bit field.
// R8: Move instructions with direct addressing use a full 16-bit field.
// R9: Stack pointer marks next free word, post-increments on push, pre-decrements on pop.
// R10: Call push clears the counter's top byte.
// R11: Exception push places low status byte in the counter's top byte.
// R12: Stack limit has no reset value and its bit 0 is always zero.
// R13: Push at limit does not trap; the next push beyond it traps.
// R14: Stack address below 0x0800 raises a stack error trap.
// R15: Software avoids stack-pointer indirect read right after a limit write.
// R16: Modulo works on any register and corrects addresses strictly beyond bounds.
// R17: Corrected address written back only for pre/post modify, not offset mode.
// R18: Bit-reversed addressing only in X generator and only for writes.
// R19: Bit reversal needs pointer select not 15, enable bit 15, pre/post increment.
// R20: Bit-reversed word writes add reversed modifier, ignore offset, clear address LSb.
// R21: Software sets modifier to half the buffer size in words.
// R22: Software aligns a 2^N-byte reversed buffer to N zero low bits.
// R23: Reversed addition carries from the top bit toward the bottom bit.
`timescale 1ns/10ps
module agu_top
  import agu_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RESET_N,
  input  wire logic [AGU_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [AGU_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  input  wire agu_tbl_req_t          TBL_REQ,
  output logic [15:0]                TBL_DATA,
  output logic                       TBL_VALID,
  input  wire agu_wld_req_t          WLD_REQ,
  output logic [15:0]                WLD_RESULT,
  output logic                       WLD_VALID,
  input  wire agu_dir_req_t          DIR_REQ,
  output logic [15:0]                DIR_ADDR,
  output logic                       DIR_VALID,
  input  wire logic                  PC_ADVANCE,
  input  wire logic                  PC_LOAD,
  input  wire logic [23:0]           PC_LOAD_VAL,
  output logic [23:0]                PC,
  input  wire logic [7:0]            STATUS_LOW,
  input  wire agu_stk_req_t          STK_REQ,
  output logic [15:0]                STK_EA,
  output logic [15:0]                STK_WDATA,
  output logic                       STK_VALID,
  output logic                       STK_TRAP,
  output logic [15:0]                STK_POINTER,
  input  wire agu_ea_req_t           EA_REQ,
  output agu_ea_rsp_t                EA_RSP
);

  // ****************************************
  // Register bus slave
  // ****************************************
  function automatic logic reg_hit(input logic [AGU_ADDR_W-1:0] a, input logic [7:0] off);
    return a[AGU_ADDR_W-1:2] == off[AGU_ADDR_W-1:2];
  endfunction

  logic                  aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [AGU_ADDR_W-1:0] awaddr_q, wr_addr;
  logic [31:0]           wdata_q, rdata_q, wr_data, rd_mux;
  logic [3:0]            wstrb_q, wr_strb;
  logic [1:0]            bresp_q, rresp_q;
  logic                  have_aw, have_w, wr_fire, wr_known, rd_fire, rd_known;
  logic [15:0]           stack_limit_q, bitrev_q, modctl_q, sp_q, limit_eff;
  logic [1:0]            status_q, status_set, status_clr;
  logic [23:0]           pc_q;

  assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_hold_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  assign have_aw  = aw_hold_q || (S_AXI_AWVALID && S_AXI_AWREADY);
  assign have_w   = w_hold_q || (S_AXI_WVALID && S_AXI_WREADY);
  assign wr_addr  = aw_hold_q ? awaddr_q : S_AXI_AWADDR;
  assign wr_data  = w_hold_q ? wdata_q : S_AXI_WDATA;
  assign wr_strb  = w_hold_q ? wstrb_q : S_AXI_WSTRB;
  assign wr_fire  = have_aw && have_w && !bvalid_q;
  assign wr_known = reg_hit(wr_addr, AGU_REG_STK_LIMIT) || reg_hit(wr_addr, AGU_REG_BITREV) ||
                    reg_hit(wr_addr, AGU_REG_MODCTL) || reg_hit(wr_addr, AGU_REG_STATUS) ||
                    reg_hit(wr_addr, AGU_REG_SP);
  assign rd_fire  = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AGU_RESP_OKAY;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b1;
      bresp_q   <= wr_known ? AGU_RESP_OKAY : AGU_RESP_SLVERR;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux   = 32'h00000000;
    rd_known = 1'b1;
    unique case (S_AXI_ARADDR[AGU_ADDR_W-1:2])
      AGU_REG_STK_LIMIT[7:2]: rd_mux[15:0] = limit_eff;
      AGU_REG_BITREV[7:2]:    rd_mux[15:0] = bitrev_q;
      AGU_REG_MODCTL[7:2]:    rd_mux[15:0] = modctl_q;
      AGU_REG_STATUS[7:2]:    rd_mux[1:0]  = status_q;
      AGU_REG_SP[7:2]:        rd_mux[15:0] = sp_q;
      AGU_REG_PC[7:2]:        rd_mux[23:0] = pc_q;
      default:                rd_known     = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= AGU_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_known ? AGU_RESP_OKAY : AGU_RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Limit deliberately has no reset
  always_ff @(posedge REF_CLK) begin
    if (wr_fire && reg_hit(wr_addr, AGU_REG_STK_LIMIT)) begin
      if (wr_strb[0]) stack_limit_q[7:0] <= wr_data[7:0];
      if (wr_strb[1]) stack_limit_q[15:8] <= wr_data[15:8];
    end
  end
  assign limit_eff = stack_limit_q & AGU_ALIGN_MASK; // [R12]

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      bitrev_q <= AGU_BITREV_RST;
      modctl_q <= AGU_MODCTL_RST;
    end else if (wr_fire) begin
      if (reg_hit(wr_addr, AGU_REG_BITREV) && wr_strb[0]) bitrev_q[7:0] <= wr_data[7:0];
      if (reg_hit(wr_addr, AGU_REG_BITREV) && wr_strb[1]) bitrev_q[15:8] <= wr_data[15:8];
      if (reg_hit(wr_addr, AGU_REG_MODCTL) && wr_strb[0]) modctl_q[7:0] <= wr_data[7:0];
      if (reg_hit(wr_addr, AGU_REG_MODCTL) && wr_strb[1]) modctl_q[15:8] <= wr_data[15:8];
    end
  end

  // Sticky error flags, write one to clear, set wins
  assign status_clr = (wr_fire && reg_hit(wr_addr, AGU_REG_STATUS) && wr_strb[0]) ? wr_data[1:0] : 2'h0;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      status_q <= AGU_STATUS_RST;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  // ****************************************
  // Table lanes, byte loads, direct reach
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      TBL_DATA  <= 16'h0000;
      TBL_VALID <= 1'b0;
    end else begin
      TBL_VALID <= TBL_REQ.valid;
      if (TBL_REQ.valid) begin
        unique case ({TBL_REQ.high, TBL_REQ.byte_op})
          2'b00: TBL_DATA <= TBL_REQ.word[15:0]; // [R1]
          2'b01: TBL_DATA <= {8'h00, TBL_REQ.byte_sel ? TBL_REQ.word[15:8] : TBL_REQ.word[7:0]}; // [R2]
          2'b10: TBL_DATA <= {8'h00, TBL_REQ.word[23:16]}; // [R3]
          2'b11: TBL_DATA <= {8'h00, TBL_REQ.byte_sel ? 8'h00 : TBL_REQ.word[23:16]}; // [R4]
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      WLD_RESULT <= 16'h0000;
      WLD_VALID  <= 1'b0;
      DIR_ADDR   <= 16'h0000;
      DIR_VALID  <= 1'b0;
    end else begin
      WLD_VALID <= WLD_REQ.valid;
      DIR_VALID <= DIR_REQ.valid;
      if (WLD_REQ.valid) begin
        WLD_RESULT <= WLD_REQ.byte_op ? {WLD_REQ.old_val[15:8], WLD_REQ.load_val[7:0]} : WLD_REQ.load_val; // [R6]
      end
      if (DIR_REQ.valid) begin
        DIR_ADDR <= DIR_REQ.mov_form ? DIR_REQ.field : {3'h0, DIR_REQ.field[12:0]}; // [R7] [R8]
      end
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      pc_q <= AGU_PC_RST;
    end else if (PC_LOAD) begin
      pc_q <= PC_LOAD_VAL & {16'hFFFF, AGU_ALIGN_MASK[7:0]};
    end else if (PC_ADVANCE) begin
      pc_q <= pc_q + AGU_PC_STEP; // [R5]
    end
  end
  assign PC = pc_q;

  // ****************************************
  // Software stack
  // ****************************************
  logic [15:0] stk_ea;
  logic [15:0] stk_data;
  logic [7:0]  pc_top;

  assign stk_ea = STK_REQ.push ? sp_q : sp_q - AGU_WORD_STEP; // [R9]
  assign pc_top = STK_REQ.exc ? STATUS_LOW : 8'h00; // [R10] [R11]
  assign stk_data = !STK_REQ.pc_word ? STK_REQ.data :
                    STK_REQ.pc_hi ? {pc_top, pc_q[23:16]} : pc_q[15:0];

  always_comb begin
    status_set = 2'h0;
    if (STK_REQ.push && sp_q > limit_eff) status_set[AGU_ST_LIMIT_BIT] = 1'b1; // [R13]
    if ((STK_REQ.push || STK_REQ.pop) && stk_ea < AGU_SFR_END) status_set[AGU_ST_UNDER_BIT] = 1'b1; // [R14]
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      sp_q <= AGU_SP_RST;
    end else if (STK_REQ.push) begin
      sp_q <= sp_q + AGU_WORD_STEP; // [R9]
    end else if (STK_REQ.pop) begin
      sp_q <= sp_q - AGU_WORD_STEP; // [R9]
    end else if (wr_fire && reg_hit(wr_addr, AGU_REG_SP) && (&wr_strb[1:0])) begin
      sp_q <= wr_data[15:0] & AGU_ALIGN_MASK;
    end
  end
  assign STK_POINTER = sp_q;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      STK_EA    <= 16'h0000;
      STK_WDATA <= 16'h0000;
      STK_VALID <= 1'b0;
      STK_TRAP  <= 1'b0;
    end else begin
      STK_VALID <= STK_REQ.push || STK_REQ.pop;
      STK_TRAP  <= |status_set; // [R13] [R14]
      if (STK_REQ.push || STK_REQ.pop) begin
        STK_EA    <= stk_ea;
        STK_WDATA <= stk_data;
      end
    end
  end

  // ****************************************
  // Indirect EA: modulo and bit reversal
  // ****************************************
  logic        br_act, pre_post;
  logic [15:0] nxt, len, fixed, rev;
  agu_ea_rsp_t rsp_d;

  assign pre_post = EA_REQ.mode == AGU_MODE_PRE || EA_REQ.mode == AGU_MODE_POST;
  assign br_act   = EA_REQ.xagu && EA_REQ.write && !EA_REQ.byte_op && pre_post && !EA_REQ.dec && // [R18] [R20]
                    modctl_q[AGU_BWM_LSB +: 4] != AGU_BWM_NONE && bitrev_q[AGU_BITREV_ENABLE_BIT] &&   // [R19]
                    modctl_q[AGU_BWM_LSB +: 4] == EA_REQ.wsel;
  assign rev      = agu_rev_add(EA_REQ.ptr & AGU_ALIGN_MASK, {bitrev_q[14:0], 1'b0}) & AGU_ALIGN_MASK; // [R20] [R23]
  assign len      = EA_REQ.mod_end - EA_REQ.mod_start + 16'h0001;
  assign nxt      = EA_REQ.mode == AGU_MODE_OFFSET ? EA_REQ.ptr + EA_REQ.offset :
                    EA_REQ.dec ? EA_REQ.ptr - EA_REQ.step : EA_REQ.ptr + EA_REQ.step;

  always_comb begin
    fixed = nxt;
    if (EA_REQ.mod_en && !EA_REQ.dec && nxt > EA_REQ.mod_end) fixed = nxt - len; // [R16]
    if (EA_REQ.mod_en && EA_REQ.dec && nxt < EA_REQ.mod_start) fixed = nxt + len; // [R16]
    rsp_d        = '0;
    rsp_d.valid  = EA_REQ.valid;
    rsp_d.bitrev = br_act;
    rsp_d.wb_en  = pre_post && EA_REQ.valid; // [R17]
    rsp_d.wb_val = !pre_post ? EA_REQ.ptr : br_act ? rev : fixed; // [R17]
    unique case (EA_REQ.mode)
      AGU_MODE_PRE:    rsp_d.ea = br_act ? rev : fixed;
      AGU_MODE_POST:   rsp_d.ea = br_act ? EA_REQ.ptr & AGU_ALIGN_MASK : EA_REQ.ptr;
      AGU_MODE_OFFSET: rsp_d.ea = fixed;
      AGU_MODE_PLAIN:  rsp_d.ea = EA_REQ.ptr;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      EA_RSP <= '0;
    end else begin
      EA_RSP <= rsp_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  AST_TBL_LOW_WORD: assert property (TBL_REQ.valid && !TBL_REQ.high && !TBL_REQ.byte_op // [R1]
    |=> TBL_VALID && TBL_DATA == $past(TBL_REQ.word[15:0])) else $error("low lane word wrong");
  AST_TBL_LOW_BYTE: assert property (TBL_REQ.valid && !TBL_REQ.high && TBL_REQ.byte_op && TBL_REQ.byte_sel // [R2]
    |=> TBL_DATA[7:0] == $past(TBL_REQ.word[15:8])) else $error("low lane upper byte wrong");
  AST_TBL_HIGH_WORD: assert property (TBL_REQ.valid && TBL_REQ.high && !TBL_REQ.byte_op // [R3]
    |=> TBL_DATA == {8'h00, $past(TBL_REQ.word[23:16])}) else $error("high lane word wrong");
  AST_TBL_HIGH_BYTE: assert property (TBL_REQ.valid && TBL_REQ.high && TBL_REQ.byte_op && TBL_REQ.byte_sel // [R4]
    |=> TBL_DATA == 16'h0000) else $error("high lane byte not zero");
  AST_PC_STEP: assert property (PC_ADVANCE && !PC_LOAD |=> PC == $past(PC) + AGU_PC_STEP) // [R5]
    else $error("pc did not advance by two");
  AST_BYTE_LOAD: assert property (WLD_REQ.valid && WLD_REQ.byte_op // [R6]
    |=> WLD_RESULT[15:8] == $past(WLD_REQ.old_val[15:8])) else $error("byte load touched high byte");
  AST_NEAR: assert property (DIR_REQ.valid && !DIR_REQ.mov_form |=> DIR_ADDR < 16'h2000) // [R7]
    else $error("near address out of range");
  AST_PUSH_POP: assert property (STK_REQ.push ##1 !STK_REQ.push && !STK_REQ.pop && !wr_fire ##1 STK_REQ.pop && // [R9]
    !STK_REQ.push |=> STK_POINTER == $past(STK_POINTER, 3) && STK_EA == $past(STK_POINTER, 3))
    else $error("stack pointer walk wrong");
  AST_CALL_PUSH: assert property (STK_REQ.push && STK_REQ.pc_word && STK_REQ.pc_hi && !STK_REQ.exc // [R10]
    |=> STK_WDATA[15:8] == 8'h00) else $error("call push top byte not clear");
  AST_LIMIT_EQUAL: assert property (STK_REQ.push && STK_POINTER == limit_eff && STK_POINTER >= AGU_SFR_END // [R13]
    |=> !STK_TRAP) else $error("push at limit trapped");
  AST_LIMIT_NEXT: assert property (STK_REQ.push && STK_POINTER == limit_eff + AGU_WORD_STEP // [R13]
    |=> STK_TRAP) else $error("push past limit not trapped");
  AST_UNDERFLOW: assert property (STK_REQ.pop && !STK_REQ.push && STK_POINTER >= AGU_WORD_STEP && // [R14]
    STK_POINTER < AGU_SFR_END + AGU_WORD_STEP |=> STK_TRAP && status_q[AGU_ST_UNDER_BIT])
    else $error("underflow not trapped");
  AST_OFFSET_NO_WB: assert property (EA_REQ.valid && EA_REQ.mode == AGU_MODE_OFFSET |=> !EA_RSP.wb_en) // [R17]
    else $error("offset mode wrote back");
  AST_BITREV_LSB: assert property (EA_REQ.valid && br_act |=> EA_RSP.bitrev && !EA_RSP.ea[0] && !EA_RSP.wb_val[0]) // [R20]
    else $error("bit reversed address odd");

  COV_BITREV: cover property (EA_REQ.valid && br_act && EA_REQ.mode == AGU_MODE_PRE);
  COV_MOD_WRAP: cover property (EA_REQ.valid && EA_REQ.mod_en && fixed != nxt);
  COV_LIMIT_TRAP: cover property (STK_REQ.push && STK_POINTER == limit_eff ##2 STK_REQ.push ##1 STK_TRAP);
  COV_EXC_PUSH: cover property (STK_REQ.push && STK_REQ.pc_word && STK_REQ.exc);

endmodule

// ---- agu_pkg.sv ----
// Shared constants, carrier structs and the reversed-carry helper function of the address generation unit
package agu_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam int          AGU_ADDR_W        = 8;
  localparam logic [7:0]  AGU_REG_STK_LIMIT = 8'h00;
  localparam logic [7:0]  AGU_REG_BITREV    = 8'h04;
  localparam logic [7:0]  AGU_REG_MODCTL    = 8'h08;
  localparam logic [7:0]  AGU_REG_STATUS    = 8'h0C;
  localparam logic [7:0]  AGU_REG_SP        = 8'h10;
  localparam logic [7:0]  AGU_REG_PC        = 8'h14;
  localparam int          AGU_BITREV_ENABLE_BIT      = 15;
  localparam int          AGU_BWM_LSB       = 0;
  localparam int          AGU_ST_LIMIT_BIT  = 0;
  localparam int          AGU_ST_UNDER_BIT  = 1;
  localparam logic [3:0]  AGU_BWM_NONE      = 4'hF;
  localparam logic [15:0] AGU_BITREV_RST    = 16'h0000;
  localparam logic [15:0] AGU_MODCTL_RST    = 16'h000F;
  localparam logic [15:0] AGU_SP_RST        = 16'h0800;
  localparam logic [23:0] AGU_PC_RST        = 24'h000000;
  localparam logic [1:0]  AGU_STATUS_RST    = 2'h0;

  // ****************************************
  // Address space figures
  // ****************************************
  localparam logic [15:0] AGU_SFR_END       = 16'h0800;
  localparam logic [15:0] AGU_WORD_STEP     = 16'h0002;
  localparam logic [23:0] AGU_PC_STEP       = 24'h000002;
  localparam logic [15:0] AGU_ALIGN_MASK    = 16'hFFFE;
  localparam logic [1:0]  AGU_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  AGU_RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    AGU_MODE_PRE    = 2'h0,
    AGU_MODE_POST   = 2'h1,
    AGU_MODE_PLAIN  = 2'h3,
    AGU_MODE_OFFSET = 2'h2
  } agu_mode_t;

  // ****************************************
  // Carrier structs
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        high;
    logic        byte_op;
    logic        byte_sel;
    logic [23:0] word;
  } agu_tbl_req_t;

  typedef struct packed {
    logic        valid;
    logic        byte_op;
    logic [15:0] old_val;
    logic [15:0] load_val;
  } agu_wld_req_t;

  typedef struct packed {
    logic        valid;
    logic        mov_form;
    logic [15:0] field;
  } agu_dir_req_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic        pc_word;
    logic        pc_hi;
    logic        exc;
    logic [15:0] data;
  } agu_stk_req_t;

  typedef struct packed {
    logic        valid;
    agu_mode_t   mode;
    logic        dec;
    logic [3:0]  wsel;
    logic [15:0] ptr;
    logic [15:0] step;
    logic [15:0] offset;
    logic        mod_en;
    logic [15:0] mod_start;
    logic [15:0] mod_end;
    logic        byte_op;
    logic        write;
    logic        xagu;
  } agu_ea_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [15:0] wb_val;
    logic        bitrev;
  } agu_ea_rsp_t;

  // Addition with carries running from the top bit down
  function automatic logic [15:0] agu_rev_add(input logic [15:0] a, input logic [15:0] m);
    logic        c;
    logic [15:0] s;
    c = 1'b0;
    s = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      s[i] = a[i] ^ m[i] ^ c;
      c    = (a[i] & m[i]) | (a[i] & c) | (m[i] & c);
    end
    return s;
  endfunction

endpackage

// ---- agu_cpu_model.sv ----
// Decoder-side model: reversed buffer setup and next reversed address
`timescale 1ns/10ps
module agu_cpu_model (
  input  wire logic [15:0] ptr,
  output logic [15:0]      modifier,
  output logic [15:0]      base,
  output logic [15:0]      next_ea
);
  // ****************
  // Buffer setup
  // ****************
  assign modifier = 16'h0004;
  assign base     = 16'h1000;
  always_comb begin
    logic [15:0] a;
    logic [15:0] m;
    logic        c;
    a = ptr & 16'hFFFE;
    m = modifier << 1;
    c = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      next_ea[k] = a[k] ^ m[k] ^ c;
      c          = (a[k] & m[k]) | (c & (a[k] | m[k]));
    end
    next_ea[0] = 1'b0; // Carry below bit 1 dropped
  end
endmodule

// ---- tb_address_generation_unit.sv ----
// Self-checking bench of the address generation unit
`timescale 1ns/10ps
module tb_address_generation_unit
  import agu_pkg::*;
;
  logic         REF_CLK = 0, RESET_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic         S_AXI_ARVALID = 0, S_AXI_RREADY = 0, PC_ADVANCE = 0, PC_LOAD = 0;
  logic         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic         TBL_VALID, WLD_VALID, DIR_VALID, STK_VALID, STK_TRAP;
  logic [7:0]   S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, STATUS_LOW = 0;
  logic [3:0]   S_AXI_WSTRB = 4'hF;
  logic [31:0]  S_AXI_WDATA = 0, S_AXI_RDATA, rd;
  logic [1:0]   S_AXI_BRESP, S_AXI_RRESP, rr;
  logic [23:0]  PC_LOAD_VAL = 24'hABCDEF, PC, w;
  logic [15:0]  TBL_DATA, WLD_RESULT, DIR_ADDR, STK_EA, STK_WDATA, STK_POINTER, mdf, base, nxt, p, q, e;
  agu_tbl_req_t TBL_REQ = '0;
  agu_wld_req_t WLD_REQ = '0;
  agu_dir_req_t DIR_REQ = '0;
  agu_stk_req_t STK_REQ = '0;
  agu_ea_req_t  EA_REQ = '0;
  agu_ea_rsp_t  EA_RSP;
  int           fails = 0, tests_run = 0, cyc = 0, i;
  agu_top uut (.REF_CLK, .RESET_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TBL_REQ, .TBL_DATA, .TBL_VALID,
    .WLD_REQ, .WLD_RESULT, .WLD_VALID, .DIR_REQ, .DIR_ADDR, .DIR_VALID, .PC_ADVANCE, .PC_LOAD, .PC_LOAD_VAL, .PC,
    .STATUS_LOW, .STK_REQ, .STK_EA, .STK_WDATA, .STK_VALID, .STK_TRAP, .STK_POINTER, .EA_REQ, .EA_RSP);
  agu_cpu_model cpu (.ptr(p), .modifier(mdf), .base(base), .next_ea(nxt));
  initial forever #4 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************
  // Register bus
  // ****************
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK) {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'b111};
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
    do @(posedge REF_CLK); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge REF_CLK) {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
    do @(posedge REF_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 0;
    do @(posedge REF_CLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 0;
    {rr, rd} = {S_AXI_RRESP, S_AXI_RDATA};
  endtask
  initial begin
    i = $urandom(48076);
    repeat (6) @(posedge REF_CLK);
    RESET_N <= 1;
    #1 chk({PC, STK_POINTER}, {AGU_PC_RST, AGU_SP_RST});
    for (i = 0; i < 8; i++) begin
      w = 24'($urandom);
      p = 16'($urandom);
      q = 16'($urandom);
      @(posedge REF_CLK) TBL_REQ <= '{1'b1, i[2], i[1], i[0], w};
      WLD_REQ <= '{1'b1, i[0], p, q};
      DIR_REQ <= '{1'b1, i[0], q};
      @(posedge REF_CLK) {TBL_REQ.valid, WLD_REQ.valid, DIR_REQ.valid} <= 3'b000;
      e = i[2] ? {8'h00, (i[1] && i[0]) ? 8'h00 : w[23:16]} : (i[1] ? {8'h00, i[0] ? w[15:8] : w[7:0]} : w[15:0]);
      #1 chk({TBL_VALID, i[1] ? {8'h00, TBL_DATA[7:0]} : TBL_DATA}, {1'b1, e});
      chk({WLD_VALID, WLD_RESULT}, {1'b1, i[0] ? {p[15:8], q[7:0]} : q});
      chk({DIR_VALID, DIR_ADDR}, {1'b1, i[0] ? q : {3'b000, q[12:0]}});
    end
    @(posedge REF_CLK) PC_LOAD <= 1;
    @(posedge REF_CLK) {PC_LOAD, PC_ADVANCE} <= 2'b01;
    repeat (3) @(posedge REF_CLK);
    PC_ADVANCE <= 0;
    #1 chk(PC, 24'hABCDF4);
    axw(AGU_REG_STK_LIMIT, 32'h00000803); // no stack access right after
    axr(AGU_REG_STK_LIMIT);
    chk({rr, rd}, {AGU_RESP_OKAY, 32'h00000802});
    axr(8'h3C);
    chk({rr, rd}, {AGU_RESP_SLVERR, 32'h0});
    q = AGU_SP_RST;
    for (i = 0; i < 7; i++) begin
      @(posedge REF_CLK) STK_REQ <= '{i < 3, i >= 3, 1'b0, 1'b0, 1'b0, 16'h5A5A};
      @(posedge REF_CLK) STK_REQ <= '0;
      if (i >= 3) q = q - 16'h0002;
      e = i < 3 ? q + 16'h0002 : q;
      #1 chk({STK_VALID, STK_TRAP, STK_EA, STK_POINTER}, {1'b1, (i < 3 && q > 16'h0802) || q < 16'h0800, q, e});
      q = e;
    end
    axr(AGU_REG_STATUS);
    chk(rd, 32'h00000003);
    for (i = 0; i < 2; i++) begin
      @(posedge REF_CLK) STATUS_LOW <= 8'($urandom);
      STK_REQ <= '{1'b1, 1'b0, 1'b1, 1'b1, i[0], 16'h0000};
      @(posedge REF_CLK) STK_REQ <= '0;
      #1 chk(STK_WDATA, {i[0] ? STATUS_LOW : 8'h00, 8'hAB});
    end
    axw(AGU_REG_BITREV, {16'h0000, 16'h8000 | mdf});
    axw(AGU_REG_MODCTL, 32'h00000001);
    p = base;
    for (i = 0; i < 12; i++) begin
      @(posedge REF_CLK) EA_REQ <= '{1'b1, i == 11 ? AGU_MODE_OFFSET : (i == 9 ? AGU_MODE_POST : AGU_MODE_PRE), 1'b0,
        i == 8 ? 4'h2 : 4'h1, p, 16'h0002, 16'h0010, i == 10, p, p + 16'h0001, i == 9, 1'b1, i != 10};
      @(posedge REF_CLK) EA_REQ.valid <= 1'b0;
      e = i < 8 ? nxt : (i == 9 || i == 10) ? p : p + (i == 11 ? 16'h0010 : 16'h0002);
      #1 chk({EA_RSP.valid, EA_RSP.ea, EA_RSP.wb_en, EA_RSP.bitrev}, {1'b1, e, i != 11, i < 8});
      if (i != 11) chk(EA_RSP.wb_val, i < 8 ? nxt : (i == 10 ? p : p + 16'h0002));
      if (i < 8) p = nxt;
    end
    final_report();
  end
endmodule
